//--- logic/adcc_conversion_control.sv
// control logic of a 10-bit successive approximation converter
`timescale 1ns/1ps
module adcc_conversion_control
    import adcc_pkg::*;
#(
    parameter int TRIG_N = 7
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // register bus, AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // trigger sources, synchronous to sys_clk
    input wire logic [TRIG_N-1:0] trigIn,
    // analog core
    input wire logic [ADCC_RES_W-1:0] anaResult,
    input wire logic chanIsDiff,
    output adcc_ana_t anaCtl,
    output logic halfRatePhaseClock
);

    adcc_state_t s;
    adcc_state_t next_s;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] alignRes(input logic [ADCC_RES_W-1:0] r,
                                             input logic left);
        if (left) begin
            alignRes = {r, 6'h00};
        end else begin
            alignRes = {6'h00, r};
        end
    endfunction

    function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
        isReg = (a == ofs);
    endfunction

    logic [ADCC_PRE_W-1:0] preMax;
    logic [ADCC_PRE_W-1:0] preHalf;
    logic rise;
    logic fall;
    logic trigLevel;
    logic trigEdge;
    logic goReq;
    logic flagClr;
    logic freeMode;
    logic [15:0] resView;
    logic [7:0] rdAddr;

    always_comb begin
        // ratio is 2 << divide select
        preMax = ADCC_PRE_W'((ADCC_PRE_BASE << s.div) - 9'h001);
        preHalf = preMax >> 1;
        rise = s.on && (s.pre >= preMax); // a smaller ratio takes effect without a full wrap
        fall = s.on && (s.pre == preHalf);
        trigLevel = 1'b0;
        if (s.trigSel != ADCC_TRIG_FREE &&
            int'(s.trigSel) <= TRIG_N) begin
            trigLevel = trigIn[int'(s.trigSel) - 1];
        end
        freeMode = s.auto && (s.trigSel == ADCC_TRIG_FREE);
        trigEdge = s.on && s.auto && !freeMode &&
                   s.trigSync[ADCC_SYNC_STAGES-1] && !s.trigPrev;
        resView = alignRes(s.res, s.align);
        rdAddr = haddr[7:0];
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s = s;
        next_s.ana.sample = 1'b0;
        next_s.ana.done = 1'b0;
        goReq = 1'b0;
        flagClr = 1'b0;

        // address phase: zero wait, read data registered here
        next_s.wrPend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            next_s.wrPend = hwrite;
            next_s.wrAddr = rdAddr;
            if (!hwrite) begin
                next_s.hrdata = 32'h0000_0000;
                if (isReg(rdAddr, ADCC_OFS_CTRL_A)) begin
                    next_s.hrdata[ADCC_A_ON] = s.on;
                    next_s.hrdata[ADCC_A_GO] = s.go;
                    next_s.hrdata[ADCC_A_AUTO] = s.auto;
                    next_s.hrdata[ADCC_A_FLAG] = s.flag;
                    next_s.hrdata[ADCC_A_DIV_LSB +: ADCC_DIV_W] = s.div;
                end else if (isReg(rdAddr, ADCC_OFS_CTRL_B)) begin
                    next_s.hrdata[ADCC_B_TRIG_LSB +: ADCC_TRIG_W] = s.trigSel;
                end else if (isReg(rdAddr, ADCC_OFS_INSEL)) begin
                    next_s.hrdata[ADCC_S_REF_LSB +: ADCC_REF_W] = s.refSel;
                    next_s.hrdata[ADCC_S_ALIGN] = s.align;
                    next_s.hrdata[ADCC_S_CHAN_LSB +: ADCC_CHAN_W] = s.chan;
                end else if (isReg(rdAddr, ADCC_OFS_RES_LO)) begin
                    next_s.hrdata[7:0] = resView[7:0];
                    next_s.lock = 1'b1;
                end else if (isReg(rdAddr, ADCC_OFS_RES_HI)) begin
                    next_s.hrdata[7:0] = resView[15:8];
                    next_s.lock = 1'b0;
                end else if (isReg(rdAddr, ADCC_OFS_STATUS)) begin
                    next_s.hrdata[ADCC_ST_BUSY] = (s.phase == ADCC_CONV);
                    next_s.hrdata[ADCC_ST_LOCK] = s.lock;
                    next_s.hrdata[ADCC_ST_FIRST] = s.first;
                    next_s.hrdata[ADCC_ST_PHASE] = s.halfRate;
                end
            end
        end

        // data phase of a write
        if (s.wrPend) begin
            if (isReg(s.wrAddr, ADCC_OFS_CTRL_A)) begin
                next_s.on = hwdata[ADCC_A_ON];
                next_s.auto = hwdata[ADCC_A_AUTO];
                next_s.div = hwdata[ADCC_A_DIV_LSB +: ADCC_DIV_W];
                goReq = hwdata[ADCC_A_GO] && hwdata[ADCC_A_ON];
                flagClr = hwdata[ADCC_A_FLAG];
            end else if (isReg(s.wrAddr, ADCC_OFS_CTRL_B)) begin
                next_s.trigSel = hwdata[ADCC_B_TRIG_LSB +: ADCC_TRIG_W];
            end else if (isReg(s.wrAddr, ADCC_OFS_INSEL)) begin
                next_s.refSel = hwdata[ADCC_S_REF_LSB +: ADCC_REF_W];
                next_s.align = hwdata[ADCC_S_ALIGN];
                next_s.chan = hwdata[ADCC_S_CHAN_LSB +: ADCC_CHAN_W];
            end
        end
        // write-one clears; a completion below still wins
        if (flagClr) begin
            next_s.flag = 1'b0;
        end

        // prescaler and half rate phase clock
        if (!s.on) begin
            next_s.pre = '0;
            next_s.halfRate = 1'b0;
        end else begin
            next_s.pre = rise ? '0 : ADCC_PRE_W'(s.pre + 8'h01);
            if (rise) begin
                next_s.halfRate = !s.halfRate;
            end
        end

        // trigger synchroniser, three stages
        next_s.trigSync = {s.trigSync[ADCC_SYNC_STAGES-2:0], trigLevel};
        next_s.trigPrev = s.trigSync[ADCC_SYNC_STAGES-1];

        // conversion sequencing
        case (s.phase)
            ADCC_IDLE: begin
                if (goReq) begin
                    next_s.go = 1'b1;
                    next_s.phase = ADCC_PEND;
                end else if (trigEdge) begin
                    next_s.go = 1'b1;
                    next_s.pre = '0;
                    next_s.halfRate = 1'b0;
                    next_s.halfCnt = '0;
                    next_s.phase = ADCC_CONV;
                    next_s.smpH = s.first ? ADCC_FIRST_SMP_H : ADCC_AUTO_SMP_H;
                    next_s.lenH = s.first ? ADCC_FIRST_LEN_H : ADCC_AUTO_LEN_H;
                end
            end
            ADCC_PEND: begin
                // waits for the converter clock edge, not the write
                if (rise) begin
                    next_s.phase = ADCC_CONV;
                    next_s.halfCnt = '0;
                    if (s.first) begin
                        next_s.smpH = ADCC_FIRST_SMP_H;
                        next_s.lenH = ADCC_FIRST_LEN_H;
                    end else if (chanIsDiff && s.halfRate) begin
                        next_s.smpH = ADCC_DIFF_SMP_H;
                        next_s.lenH = ADCC_DIFF_LEN_H;
                    end else begin
                        next_s.smpH = ADCC_NORM_SMP_H;
                        next_s.lenH = ADCC_NORM_LEN_H;
                    end
                end
            end
            ADCC_CONV: begin
                // trigger edges fall through here unused
                if (rise || fall) begin
                    next_s.halfCnt = ADCC_HC_W'(s.halfCnt + 6'h01);
                    if (next_s.halfCnt == s.smpH) begin
                        next_s.ana.sample = 1'b1;
                    end
                    if (next_s.halfCnt == s.lenH) begin
                        next_s.ana.done = 1'b1;
                        next_s.flag = 1'b1;
                        next_s.first = 1'b0;
                        if (!next_s.lock) begin
                            next_s.res = anaResult;
                        end
                        if (freeMode) begin
                            next_s.halfCnt = '0;
                            next_s.smpH = chanIsDiff ? ADCC_DIFF_SMP_H : ADCC_NORM_SMP_H;
                            next_s.lenH = chanIsDiff ? ADCC_DIFF_LEN_H : ADCC_NORM_LEN_H;
                        end else begin
                            next_s.go = 1'b0;
                            next_s.phase = ADCC_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_s.phase = ADCC_IDLE;
            end
        endcase

        // switching off aborts and rearms the long first conversion
        if (!s.on) begin
            next_s.first = 1'b1;
        end
        if (!next_s.on) begin
            next_s.phase = ADCC_IDLE;
            next_s.go = 1'b0;
        end

        // selection follows software only while enabled, and not while converting until the last cycle
        if (s.on && (s.phase != ADCC_CONV ||
                     s.halfCnt >= ADCC_HC_W'(s.lenH - ADCC_LAST_CYC_H))) begin
            next_s.ana.chan = s.chan;
            next_s.ana.refSel = s.refSel;
        end
        next_s.ana.powerOn = s.on;
        next_s.hreadyout = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.phase <= ADCC_IDLE;
            s.first <= 1'b1;
            s.hreadyout <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = 1'b0;
    assign anaCtl = s.ana;
    assign halfRatePhaseClock = s.halfRate;

endmodule

//--- include/adcc_pkg.sv
// constants, field layout and types of the converter control block
package adcc_pkg;

    // register byte offsets
    localparam logic [7:0] ADCC_OFS_CTRL_A = 8'h00;
    localparam logic [7:0] ADCC_OFS_CTRL_B = 8'h04;
    localparam logic [7:0] ADCC_OFS_INSEL = 8'h08;
    localparam logic [7:0] ADCC_OFS_RES_LO = 8'h0c;
    localparam logic [7:0] ADCC_OFS_RES_HI = 8'h10;
    localparam logic [7:0] ADCC_OFS_STATUS = 8'h14;

    // converter_control_a fields
    localparam int ADCC_A_ON = 7;
    localparam int ADCC_A_GO = 6;
    localparam int ADCC_A_AUTO = 5;
    localparam int ADCC_A_FLAG = 4;
    localparam int ADCC_A_DIV_LSB = 0;
    localparam int ADCC_DIV_W = 3;

    // converter_control_b fields
    localparam int ADCC_B_TRIG_LSB = 0;
    localparam int ADCC_TRIG_W = 3;
    localparam logic [2:0] ADCC_TRIG_FREE = 3'h0;

    // input_select_reg fields
    localparam int ADCC_S_REF_LSB = 6;
    localparam int ADCC_REF_W = 2;
    localparam int ADCC_S_ALIGN = 5;
    localparam int ADCC_S_CHAN_LSB = 0;
    localparam int ADCC_CHAN_W = 5;

    // status fields
    localparam int ADCC_ST_BUSY = 0;
    localparam int ADCC_ST_LOCK = 1;
    localparam int ADCC_ST_FIRST = 2;
    localparam int ADCC_ST_PHASE = 3;

    localparam int ADCC_RES_W = 10;
    localparam int ADCC_PRE_W = 8;
    localparam int ADCC_HC_W = 6;
    localparam int ADCC_SYNC_STAGES = 3;
    localparam logic [ADCC_PRE_W:0] ADCC_PRE_BASE = 9'h002;

    // converter cycle figures, then the same in half-cycle units
    localparam int ADCC_NORM_LEN_CYC = 13;
    localparam int ADCC_FIRST_LEN_CYC = 25;
    localparam int ADCC_DIFF_LEN_CYC = 14;
    localparam int ADCC_AUTO_SMP_CYC = 2;
    localparam logic [ADCC_HC_W-1:0] ADCC_NORM_LEN_H = 6'(2 * ADCC_NORM_LEN_CYC);
    localparam logic [ADCC_HC_W-1:0] ADCC_NORM_SMP_H = 6'(2 * 1 + 1);
    localparam logic [ADCC_HC_W-1:0] ADCC_FIRST_LEN_H = 6'(2 * ADCC_FIRST_LEN_CYC);
    localparam logic [ADCC_HC_W-1:0] ADCC_FIRST_SMP_H = 6'(2 * 13 + 1);
    localparam logic [ADCC_HC_W-1:0] ADCC_AUTO_LEN_H = 6'(2 * ADCC_NORM_LEN_CYC + 1);
    localparam logic [ADCC_HC_W-1:0] ADCC_AUTO_SMP_H = 6'(2 * ADCC_AUTO_SMP_CYC);
    localparam logic [ADCC_HC_W-1:0] ADCC_DIFF_LEN_H = 6'(2 * ADCC_DIFF_LEN_CYC);
    localparam logic [ADCC_HC_W-1:0] ADCC_DIFF_SMP_H = 6'(2 * 2 + 1);
    localparam logic [ADCC_HC_W-1:0] ADCC_LAST_CYC_H = 6'h02;

    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_PEND,
        ADCC_CONV
    } adcc_phase_t;

    // lines towards the analog sample-and-hold and approximation core
    typedef struct packed {
        logic [ADCC_CHAN_W-1:0] chan;
        logic [ADCC_REF_W-1:0] refSel;
        logic powerOn;
        logic sample;
        logic done;
    } adcc_ana_t;

    typedef struct packed {
        logic on;
        logic go;
        logic auto;
        logic flag;
        logic [ADCC_DIV_W-1:0] div;
        logic [ADCC_TRIG_W-1:0] trigSel;
        logic [ADCC_REF_W-1:0] refSel;
        logic align;
        logic [ADCC_CHAN_W-1:0] chan;
        logic [ADCC_RES_W-1:0] res;
        logic lock;
        logic first;
        adcc_phase_t phase;
        logic [ADCC_PRE_W-1:0] pre;
        logic halfRate;
        logic [ADCC_HC_W-1:0] halfCnt;
        logic [ADCC_HC_W-1:0] smpH;
        logic [ADCC_HC_W-1:0] lenH;
        logic [ADCC_SYNC_STAGES-1:0] trigSync;
        logic trigPrev;
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] hrdata;
        logic hreadyout;
        adcc_ana_t ana;
    } adcc_state_t;

endpackage

//--- verif/adcc_conversion_control_sva.sv
// assertion checker on the ports of the converter control block
`timescale 1ns/1ps
module adcc_conversion_control_sva
    import adcc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // watched outputs
    input wire logic hreadyout,
    input wire logic hresp,
    input wire adcc_ana_t anaCtl,
    input wire logic halfRatePhaseClock
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic smpSeen;
    ////////////////////////////////////////////////////////////
    // a completion without a sample would pass on a stale core value
    always_ff @(posedge sys_clk) begin
        if (sys_rst || anaCtl.done)
            smpSeen <= 1'b0;
        else if (anaCtl.sample)
            smpSeen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////
    a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not zero-wait okay");
    a_done_gap: assert property (anaCtl.done |=> (!anaCtl.done)[*8])
        else $error("completions too close together");
    a_sample_gap: assert property (anaCtl.sample |=> (!anaCtl.sample)[*8])
        else $error("samples too close together");
    a_sample_apart: assert property (!(anaCtl.sample && anaCtl.done))
        else $error("sample and completion in one cycle");
    a_done_sampled: assert property (anaCtl.done |-> smpSeen)
        else $error("completion without sample");
    a_phase_off: assert property ((!anaCtl.powerOn)[*3] |-> !halfRatePhaseClock)
        else $error("phase clock runs while disabled");
    a_sel_frozen: assert property (anaCtl.sample |=> $stable({anaCtl.chan, anaCtl.refSel})[*2])
        else $error("selection moved after sample");
    a_sel_off: assert property (!anaCtl.powerOn && !$past(anaCtl.powerOn)
        |-> $stable({anaCtl.chan, anaCtl.refSel}))
        else $error("selection applied while disabled");
    c_done: cover property (anaCtl.done);
    c_conv: cover property (anaCtl.sample ##[1:60] anaCtl.done);
    c_phase: cover property ($rose(halfRatePhaseClock));
endmodule

bind adcc_conversion_control adcc_conversion_control_sva adcc_conversion_control_sva_i (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .anaCtl(anaCtl),
    .halfRatePhaseClock(halfRatePhaseClock)
);

//--- verif/adcc_ana_model.sv
// behavioural sample-and-hold and approximation core
`timescale 1ns/1ps
module adcc_ana_model
    import adcc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // converter lines
    input wire adcc_ana_t anaCtl,
    output logic [ADCC_RES_W-1:0] anaResult,
    output logic chanIsDiff
);
    logic [ADCC_RES_W-1:0] held;
    logic busy;
    // differential pairs sit in the upper half of the channel codes
    assign chanIsDiff = anaCtl.chan[4];
    // outside a conversion the lines carry no trustworthy value
    assign anaResult = busy ? held : ~held;
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            held <= '0;
        end else if (anaCtl.sample) begin
            held <= {anaCtl.chan, anaCtl.chan};
            busy <= 1'b1;
        end else if (anaCtl.done) begin
            busy <= 1'b0;
        end
    end
endmodule

//--- verif/tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
module tb_top
    import adcc_pkg::*;
;
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] div;
        logic [7:0] lo;
        logic [7:0] hi;
    } adcc_row_t;
    // result is the channel code twice over, as the core model echoes it
    adcc_row_t rows [4] = '{32'h4a014a01, 32'h350040ad, 32'hdf02ff03, 32'ha0070000};
    logic [7:0] addrs [4] = '{ADCC_OFS_CTRL_A, ADCC_OFS_CTRL_B, ADCC_OFS_INSEL, 8'h20};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [6:0] trigIn = 7'h00;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout;
    logic hresp;
    logic halfRatePhaseClock;
    logic chanIsDiff;
    logic [ADCC_RES_W-1:0] anaResult;
    adcc_ana_t anaCtl;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int nDone = 0;
    int s;
    int t0;
    adcc_conversion_control #(.TRIG_N(7)) adcc_conversion_control_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .trigIn(trigIn), .anaResult(anaResult),
        .chanIsDiff(chanIsDiff), .anaCtl(anaCtl), .halfRatePhaseClock(halfRatePhaseClock));
    adcc_ana_model adcc_ana_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .anaCtl(anaCtl),
        .anaResult(anaResult), .chanIsDiff(chanIsDiff));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (anaCtl.done === 1'b1)
            nDone <= nDone + 1;
    end
    ////////////////////////////////////////////////////////////
    task end_of_test;
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int n, input int lo, input int hi);
        checks_done++;
        if (n < lo || n > hi) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h to %h", $time, n, lo, hi);
        end
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        if (k >= 100) begin
            n_errors++;
            end_of_test;
        end
    endtask
    // address phase held until ready, then data phase; read data taken at its edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rd = hrdata;
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        s = nDone;
        while (nDone == s && k < 20000) begin
            @(posedge sys_clk);
            k++;
        end
        if (nDone == s) begin
            n_errors++;
            end_of_test;
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge sys_clk);
        chk(hrdata, 32'h0);
        sys_rst <= 1'b0;
        foreach (addrs[i]) begin
            bus(1'b0, addrs[i], 32'h0);
            chk(rd, 32'h0);
        end
        bus(1'b1, ADCC_OFS_INSEL, 32'h0a);
        bus(1'b1, ADCC_OFS_CTRL_A, 32'hc0);
        t0 = cyc;
        wait_done;
        chk_rng(cyc - t0, 50, 56);
        // flag cleared by software with each start except the free-running one
        bus(1'b1, ADCC_OFS_CTRL_A, 32'hd0);
        t0 = cyc;
        wait_done;
        chk_rng(cyc - t0, 26, 32);
        foreach (rows[i]) begin
            bus(1'b1, ADCC_OFS_INSEL, {24'h0, rows[i].sel});
            bus(1'b1, ADCC_OFS_CTRL_A, {24'h0, 8'hd0 | rows[i].div});
            bus(1'b0, ADCC_OFS_CTRL_A, 32'h0);
            chk({31'h0, rd[ADCC_A_GO]}, 32'h1);
            wait_done;
            bus(1'b0, ADCC_OFS_CTRL_A, 32'h0);
            chk({28'h0, rd[7:4]}, 32'h9);
            bus(1'b0, ADCC_OFS_RES_LO, 32'h0);
            chk(rd, {24'h0, rows[i].lo});
            bus(1'b0, ADCC_OFS_RES_HI, 32'h0);
            chk(rd, {24'h0, rows[i].hi});
            chk({anaCtl.refSel, anaCtl.chan}, {25'h0, rows[i].sel[7:6], rows[i].sel[4:0]});
        end
        bus(1'b1, ADCC_OFS_INSEL, 32'h0a);
        bus(1'b1, ADCC_OFS_CTRL_A, 32'hd0);
        // channel moves while converting; the result must still be the old one
        bus(1'b1, ADCC_OFS_INSEL, 32'h1f);
        wait_done;
        bus(1'b0, ADCC_OFS_RES_LO, 32'h0);
        bus(1'b1, ADCC_OFS_INSEL, 32'h1f);
        bus(1'b1, ADCC_OFS_CTRL_A, 32'hd0);
        wait_done;
        bus(1'b0, ADCC_OFS_CTRL_A, 32'h0);
        chk({31'h0, rd[ADCC_A_FLAG]}, 32'h1);
        bus(1'b0, ADCC_OFS_RES_HI, 32'h0);
        chk(rd, 32'h01);
        bus(1'b0, ADCC_OFS_RES_LO, 32'h0);
        chk(rd, 32'h4a);
        bus(1'b0, ADCC_OFS_RES_HI, 32'h0);
        // single ended input, so no enable cycling between triggers
        bus(1'b1, ADCC_OFS_INSEL, 32'h0a);
        bus(1'b1, ADCC_OFS_CTRL_B, 32'h1);
        bus(1'b1, ADCC_OFS_CTRL_A, 32'hb0);
        trigIn <= 7'h01;
        t0 = cyc;
        wait_done;
        chk_rng(cyc - t0, 27, 38);
        s = nDone;
        repeat (200) @(posedge sys_clk);
        chk(nDone - s, 32'h0);
        trigIn <= 7'h00;
        repeat (4) @(posedge sys_clk);
        trigIn <= 7'h01;
        repeat (14) @(posedge sys_clk);
        trigIn <= 7'h00;
        repeat (4) @(posedge sys_clk);
        trigIn <= 7'h01;
        repeat (200) @(posedge sys_clk);
        chk(nDone - s, 32'h1);
        // clock enable low: phase clock must not toggle across one converter cycle
        ce <= 1'b0;
        @(posedge sys_clk);
        rd[0] = halfRatePhaseClock;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, halfRatePhaseClock}, {31'h0, rd[0]});
        ce <= 1'b1;
        bus(1'b1, ADCC_OFS_CTRL_B, 32'h0);
        bus(1'b1, ADCC_OFS_CTRL_A, 32'he0);
        s = nDone;
        repeat (300) @(posedge sys_clk);
        chk_rng(nDone - s, 10, 12);
        bus(1'b0, ADCC_OFS_CTRL_A, 32'h0);
        chk({31'h0, rd[ADCC_A_GO]}, 32'h1);
        bus(1'b1, ADCC_OFS_CTRL_A, 32'h0);
        bus(1'b1, ADCC_OFS_INSEL, 32'h1f);
        repeat (10) @(posedge sys_clk);
        chk({31'h0, halfRatePhaseClock}, 32'h0);
        chk({27'h0, anaCtl.chan}, 32'h0a);
        bus(1'b0, ADCC_OFS_CTRL_A, 32'h0);
        chk({31'h0, rd[ADCC_A_GO]}, 32'h0);
        // second reset in mid-run clears registers and core lines
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({21'h0, anaCtl, halfRatePhaseClock}, 32'h0);
        sys_rst <= 1'b0;
        bus(1'b0, ADCC_OFS_INSEL, 32'h0);
        chk(rd, 32'h0);
        end_of_test;
    end
endmodule
